/* rtl/mcr_pkg.sv */
package mcr_pkg;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	typedef logic [ADDR_W-1:0] mcr_addr_t;
	typedef logic [DATA_W-1:0] mcr_word_t;

	// Register offsets on the register port.
	localparam mcr_addr_t CFG_A_OFFSET = 8'h41;
	localparam mcr_addr_t CFG_B_OFFSET = 8'h42;
	localparam mcr_addr_t CLK_OFFSET = 8'h43;
	localparam mcr_addr_t SELFTEST_OFFSET = 8'h44;
	localparam mcr_addr_t STATUS_OFFSET = 8'h50;
	localparam mcr_addr_t MASK_OFFSET = 8'h51;

	// Reset values.
	localparam mcr_word_t CFG_A_RESET = 16'h0000;
	localparam mcr_word_t CFG_B_RESET = 16'h10f0;
	localparam mcr_word_t CLK_RESET = 16'h0000;
	localparam mcr_word_t SELFTEST_RESET = 16'h0000;
	localparam mcr_word_t STATUS_RESET = 16'h0000;
	localparam mcr_word_t MASK_RESET = 16'h0000;
	localparam mcr_word_t READ_IDLE = 16'h0000;

	// Bits that software can change; every other bit reads as zero.
	localparam mcr_word_t CFG_B_WMASK = 16'h30f0;
	localparam mcr_word_t CLK_WMASK = 16'hfc07;
	localparam mcr_word_t SELFTEST_WMASK = 16'hff87;

	// Field positions.
	localparam int DIG_GND_OPEN_BIT = 0;
	localparam int IO_HIGH_TH_BIT = 13;
	localparam int IO_LOW_TH_BIT = 12;
	localparam int ANALOG_HOT_LSB = 6;
	localparam int IO_HOT_LSB = 4;
	localparam int MCLK_FREQ_BIT = 2;
	localparam int OSC_WD_BIT = 1;
	localparam int MCLK_WD_BIT = 0;

	// Register port request.
	typedef struct packed {
		mcr_addr_t addr;
		mcr_word_t wrData;
		logic wrStrobe;
		logic rdStrobe;
	} mcr_bus_req_t;

	// Configuration handed to the analog monitors.
	typedef struct packed {
		mcr_word_t supplyMonitorOn;
		logic dig_ground_open_monitor_on;
		logic io_supply_high_threshold_sel;
		logic io_supply_low_threshold_sel;
		logic [1:0] analog_reg_hot_warn_sel;
		logic [1:0] io_reg_hot_warn_sel;
		logic main_clock_freq_monitor_on;
		logic diag_osc_watchdog_on;
		logic main_clock_watchdog_on;
		mcr_word_t selftestActive;
	} mcr_cfg_t;

endpackage

/* rtl/mcr_input_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module mcr_input_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Asynchronous inputs.
	input wire logic [WIDTH-1:0] asyncIn,
	// Filtered result.
	output logic [WIDTH-1:0] stableOut
);

	logic [WIDTH-1:0] stage1Reg;
	logic [WIDTH-1:0] stage2Reg;
	logic [WIDTH-1:0] stage3Reg;

	// Four flops per bit; a bit changes only once stages two and three agree,
	// which rejects a one-cycle glitch from the analog side.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1Reg <= '0;
			stage2Reg <= '0;
			stage3Reg <= '0;
			stableOut <= '0;
		end else begin
			stage1Reg <= asyncIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
			stableOut <= (stage2Reg & stage3Reg) | (stableOut & (stage2Reg | stage3Reg));
		end
	end

endmodule

`default_nettype wire

/* rtl/mcr_monitor_config.sv */
// Functional notes
// - Config A bit 0 enables ground-open monitor
// - Config B at 42h resets to 10F0h
// - Config B bits 15:14,11:8,3:0 read zero
// - Bit 13 selects I/O overvoltage threshold
// - Bit 12 selects I/O undervoltage threshold
// - Bits 7:6 select analog regulator hot warning
// - Bits 5:4 select I/O regulator hot warning
// - Clock bits 9:3 read zero; reset 0000h
// - Clock bit 2 enables frequency monitor
// - Clock bit 1 enables oscillator watchdog
// - Clock bit 0 enables main clock watchdog
// - Self-test register at 44h, resets 0000h
// - Self-test bits 15:7 map per monitor
// - Self-test acts only with monitor enabled
// - Passed self-test drives fault flag low
// - Self-test bits 6:3 read zero
// - Self-test bits 2:0 cover ground disconnects
`timescale 1ns/100ps
`default_nettype none

module mcr_monitor_config (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Register port.
	input wire mcr_pkg::mcr_bus_req_t busReq,
	output logic [mcr_pkg::DATA_W-1:0] regRdData,
	// Analog monitor side, bit layout of the self-test register.
	input wire logic [mcr_pkg::DATA_W-1:0] monitorTripIn,
	input wire logic [mcr_pkg::DATA_W-1:0] selftestDoneIn,
	// Configuration and fault flags.
	output mcr_pkg::mcr_cfg_t cfgOut,
	output logic [mcr_pkg::DATA_W-1:0] faultFlagN,
	// Interrupt.
	output logic irq
);
	import mcr_pkg::*;

	mcr_word_t cfgAReg;
	mcr_word_t cfgBReg;
	mcr_word_t clkReg;
	mcr_word_t selftestReg;
	mcr_word_t statusReg;
	mcr_word_t statusNext;
	mcr_word_t maskReg;
	mcr_word_t tripStable;
	mcr_word_t doneStable;
	mcr_word_t monitorOn;
	mcr_word_t selftestActive;
	mcr_word_t faultExpect;
	mcr_word_t faultPrevReg;
	mcr_word_t faultRise;
	logic wrCfgA;
	logic wrCfgB;
	logic wrClk;
	logic wrSelftest;
	logic wrMask;
	logic rdStatus;

	// Merge a write into a register, keeping read-only bits at zero.
	function automatic mcr_word_t mergeWrite(input mcr_word_t data, input mcr_word_t wmask);
		mergeWrite = data & wmask;
	endfunction

	// Address decode for a write strobe.
	function automatic logic hitWrite(input mcr_bus_req_t req, input mcr_addr_t offset);
		hitWrite = req.wrStrobe && (req.addr == offset);
	endfunction

	// Write decodes and the status read decode.
	assign wrCfgA = hitWrite(busReq, CFG_A_OFFSET);
	assign wrCfgB = hitWrite(busReq, CFG_B_OFFSET);
	assign wrClk = hitWrite(busReq, CLK_OFFSET);
	assign wrSelftest = hitWrite(busReq, SELFTEST_OFFSET);
	assign wrMask = hitWrite(busReq, MASK_OFFSET);
	assign rdStatus = busReq.rdStrobe && (busReq.addr == STATUS_OFFSET);

	// Analog inputs come from another domain and are filtered before use.
	mcr_input_sync #(
		.WIDTH(DATA_W)
	) tripSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.asyncIn(monitorTripIn),
		.stableOut(tripStable)
	);

	mcr_input_sync #(
		.WIDTH(DATA_W)
	) doneSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.asyncIn(selftestDoneIn),
		.stableOut(doneStable)
	);

	// Supply monitor enables, all bits writable.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfgAReg <= CFG_A_RESET;
		end else if (wrCfgA) begin
			cfgAReg <= busReq.wrData;
		end
	end

	// Thresholds; reserved bits are masked off so they stay zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfgBReg <= CFG_B_RESET;
		end else if (wrCfgB) begin
			cfgBReg <= mergeWrite(busReq.wrData, CFG_B_WMASK);
		end
	end

	// Clock monitor enables. Bits 15:10 are stored as written because
	// software is expected to write zeros there; they steer nothing.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clkReg <= CLK_RESET;
		end else if (wrClk) begin
			clkReg <= mergeWrite(busReq.wrData, CLK_WMASK);
		end
	end

	// Self-test enables.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			selftestReg <= SELFTEST_RESET;
		end else if (wrSelftest) begin
			selftestReg <= mergeWrite(busReq.wrData, SELFTEST_WMASK);
		end
	end

	// Interrupt mask, same layout as the self-test register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			maskReg <= MASK_RESET;
		end else if (wrMask) begin
			maskReg <= mergeWrite(busReq.wrData, SELFTEST_WMASK);
		end
	end

	// Each self-test bit sits at the same position as its monitor enable in
	// config A, so the gating is a plain bitwise product.
	assign monitorOn = cfgAReg & SELFTEST_WMASK;
	assign selftestActive = selftestReg & monitorOn;

	// A monitor pulls its flag low on a real trip or on a passed self-test.
	assign faultExpect = monitorOn & (tripStable | (selftestActive & doneStable));

	// Fault flags are registered so the analog side sees clean levels.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			faultFlagN <= '1;
		end else begin
			faultFlagN <= ~faultExpect;
		end
	end

	// Previous fault state, used to catch new faults as events.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			faultPrevReg <= '0;
		end else begin
			faultPrevReg <= ~faultFlagN;
		end
	end

	assign faultRise = ~faultFlagN & ~faultPrevReg;

	// Sticky status; a read clears it, but a new event in the same cycle
	// wins so no fault is lost between read and clear.
	always_comb begin
		statusNext = statusReg;
		if (rdStatus) begin
			statusNext = STATUS_RESET;
		end
		statusNext = statusNext | faultRise;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			statusReg <= STATUS_RESET;
		end else begin
			statusReg <= statusNext;
		end
	end

	// Level interrupt from registered state only.
	assign irq = |(statusReg & maskReg);

	// Read data stands in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			regRdData <= READ_IDLE;
		end else if (busReq.rdStrobe) begin
			case (busReq.addr)
				CFG_A_OFFSET: regRdData <= cfgAReg;
				CFG_B_OFFSET: regRdData <= cfgBReg;
				CLK_OFFSET: regRdData <= clkReg;
				SELFTEST_OFFSET: regRdData <= selftestReg;
				STATUS_OFFSET: regRdData <= statusReg;
				MASK_OFFSET: regRdData <= maskReg;
				default: regRdData <= READ_IDLE;
			endcase
		end else begin
			regRdData <= READ_IDLE;
		end
	end

	// Configuration outputs, decoded straight from the registers.
	always_comb begin
		cfgOut = '0;
		cfgOut.supplyMonitorOn = cfgAReg;
		cfgOut.dig_ground_open_monitor_on = cfgAReg[DIG_GND_OPEN_BIT];
		cfgOut.io_supply_high_threshold_sel = cfgBReg[IO_HIGH_TH_BIT];
		cfgOut.io_supply_low_threshold_sel = cfgBReg[IO_LOW_TH_BIT];
		cfgOut.analog_reg_hot_warn_sel = cfgBReg[ANALOG_HOT_LSB +: 2];
		cfgOut.io_reg_hot_warn_sel = cfgBReg[IO_HOT_LSB +: 2];
		cfgOut.main_clock_freq_monitor_on = clkReg[MCLK_FREQ_BIT];
		cfgOut.diag_osc_watchdog_on = clkReg[OSC_WD_BIT];
		cfgOut.main_clock_watchdog_on = clkReg[MCLK_WD_BIT];
		cfgOut.selftestActive = selftestActive;
	end

	// Checks on the register behaviour.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// A write to config A.
	sequence cfgAWrite;
		busReq.wrStrobe && busReq.addr == CFG_A_OFFSET;
	endsequence

	// A passed self-test seen by the filtered inputs.
	sequence selftestPass;
		|(selftestActive & doneStable);
	endsequence

	ground_open_on_a: assert property (cfgAWrite |=> cfgOut.dig_ground_open_monitor_on == $past(busReq.wrData[0]))
		else $error("ground open enable does not follow write");

	cfg_b_reset_a: assert property ($past(rst) |-> cfgBReg == 16'h10f0)
		else $error("config B reset value wrong");

	cfg_b_zero_a: assert property (busReq.rdStrobe && busReq.addr == CFG_B_OFFSET |=> regRdData[15:14] == 2'h0 && regRdData[11:8] == 4'h0 && regRdData[3:0] == 4'h0)
		else $error("config B reserved bits not zero");

	io_thresholds_a: assert property (wrCfgB |=> cfgOut.io_supply_high_threshold_sel == $past(busReq.wrData[13]) && cfgOut.io_supply_low_threshold_sel == $past(busReq.wrData[12]))
		else $error("I/O thresholds do not follow write");

	hot_warn_sel_a: assert property (wrCfgB |=> cfgOut.analog_reg_hot_warn_sel == $past(busReq.wrData[7:6]) && cfgOut.io_reg_hot_warn_sel == $past(busReq.wrData[5:4]))
		else $error("hot warning selects do not follow write");

	clk_zero_a: assert property (busReq.rdStrobe && busReq.addr == CLK_OFFSET |=> regRdData[9:3] == 7'h00)
		else $error("clock reserved bits not zero");

	clock_enables_a: assert property (wrClk |=> {cfgOut.main_clock_freq_monitor_on, cfgOut.diag_osc_watchdog_on, cfgOut.main_clock_watchdog_on} == $past(busReq.wrData[2:0]))
		else $error("clock enables do not follow write");

	selftest_reserved_a: assert property (busReq.rdStrobe && busReq.addr == SELFTEST_OFFSET |=> regRdData[6:3] == 4'h0)
		else $error("self-test reserved bits not zero");

	selftest_gated_a: assert property ((cfgOut.selftestActive & ~cfgAReg) == 16'h0000 && (cfgOut.selftestActive & ~selftestReg) == 16'h0000)
		else $error("self-test active without monitor enable");

	selftest_map_a: assert property (wrSelftest ##1 wrCfgA && busReq.wrData == 16'hffff |=> cfgOut.selftestActive == $past(selftestReg, 1))
		else $error("self-test bits map wrongly");

	fault_pass_a: assert property (selftestPass |=> (faultFlagN & $past(selftestActive & doneStable)) == 16'h0000)
		else $error("fault flag not low after passed self-test");

	read_only_a: assert property (wrCfgB ##1 busReq.rdStrobe && busReq.addr == CFG_B_OFFSET |=> (regRdData & ~CFG_B_WMASK) == 16'h0000)
		else $error("read-only bits changed by write");

	status_set_wins_a: assert property (rdStatus && faultRise != 16'h0000 |=> (statusReg & $past(faultRise)) == $past(faultRise))
		else $error("event lost on status clear");

	// A read of the status register with no new event leaves it empty.
	status_clear_a: assert property (rdStatus && faultRise == 16'h0000 |=> statusReg == 16'h0000)
		else $error("status not cleared by read");

	// Read data fall back to zero in any cycle that follows no read strobe.
	rd_idle_zero_a: assert property (!busReq.rdStrobe |=> regRdData == 16'h0000)
		else $error("read data not idle");

	// Reserved flag positions never report a fault.
	flag_reserved_a: assert property (faultFlagN[6:3] == 4'hf)
		else $error("reserved fault flag driven low");

	// With every monitor off, no flag may be low a cycle later.
	flags_idle_a: assert property (cfgAReg == 16'h0000 |=> faultFlagN == 16'hffff)
		else $error("fault flag low with monitors off");

	// The mask keeps only the self-test layout bits of a write.
	mask_write_a: assert property (wrMask |=> maskReg == ($past(busReq.wrData) & 16'hff87))
		else $error("mask register write wrong");

	// The interrupt follows unmasked status, a cycle after a new event.
	irq_follow_a: assert property (faultRise != 16'h0000 && (faultRise & maskReg) != 16'h0000 && !wrMask |=> irq)
		else $error("interrupt not raised for unmasked event");

endmodule

`default_nettype wire

/* verification/mcr_monitor_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none

// One comparison: counts it and reports a mismatch at once.
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin errTotal++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end

module mcr_monitor_config_tb;
	import mcr_pkg::*;

	logic ref_clk;
	logic rst;
	mcr_bus_req_t busReq;
	logic [DATA_W-1:0] regRdData;
	logic [DATA_W-1:0] monitorTripIn;
	logic [DATA_W-1:0] selftestDoneIn;
	mcr_cfg_t cfgOut;
	logic [DATA_W-1:0] faultFlagN;
	logic irq;
	int errTotal;
	int numChecks;
	mcr_word_t rd;

	mcr_monitor_config mcr_monitor_config_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.busReq(busReq),
		.regRdData(regRdData),
		.monitorTripIn(monitorTripIn),
		.selftestDoneIn(selftestDoneIn),
		.cfgOut(cfgOut),
		.faultFlagN(faultFlagN),
		.irq(irq)
	);

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// One-cycle write strobe; the edge after launch takes it. Return just past
	// that edge so the caller sees the updated register outputs.
	task automatic busWrite(input mcr_addr_t a, input mcr_word_t d);
		@(posedge ref_clk);
		busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge ref_clk);
		busReq.wrStrobe <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic busRead(input mcr_addr_t a, output mcr_word_t d);
		@(posedge ref_clk);
		busReq <= '{addr: a, wrData: 16'h0000, wrStrobe: 1'b0, rdStrobe: 1'b1};
		@(posedge ref_clk);
		busReq.rdStrobe <= 1'b0;
		#1;
		d = regRdData;
	endtask

	task automatic checkRead(input string nm, input mcr_addr_t a, input mcr_word_t e);
		mcr_word_t d;
		busRead(a, d);
		`CHK(nm, e, d)
	endtask

	// Reset contents of config A, config B, clock and self-test registers, threshold and hot-warning outputs, and the fault flags.
	task automatic testReset();
		checkRead("cfgA reset", CFG_A_OFFSET, 16'h0000);
		checkRead("cfgB reset", CFG_B_OFFSET, 16'h10f0);
		checkRead("clk reset", CLK_OFFSET, 16'h0000);
		checkRead("selftest reset", SELFTEST_OFFSET, 16'h0000);
		`CHK("low th reset", 1'b1, cfgOut.io_supply_low_threshold_sel)
		`CHK("high th reset", 1'b0, cfgOut.io_supply_high_threshold_sel)
		`CHK("analog hot reset", 2'h3, cfgOut.analog_reg_hot_warn_sel)
		`CHK("io hot reset", 2'h3, cfgOut.io_reg_hot_warn_sel)
		`CHK("flags reset", 16'hffff, faultFlagN)
		$display("test reset finished");
	endtask

	// Threshold fields over every hot-warning code, with reserved bits written as ones.
	task automatic testCfgB();
		mcr_word_t w;
		for (int i = 0; i < 4; i++) begin
			w = 16'hcf0f | (16'(i) << 6) | (16'(3 - i) << 4) | (16'(i & 1) << 13) | (16'(i >> 1) << 12);
			// Write then read with no gap between the strobes.
			@(posedge ref_clk);
			busReq <= '{addr: CFG_B_OFFSET, wrData: w, wrStrobe: 1'b1, rdStrobe: 1'b0};
			@(posedge ref_clk);
			busReq <= '{addr: CFG_B_OFFSET, wrData: 16'h0000, wrStrobe: 1'b0, rdStrobe: 1'b1};
			@(posedge ref_clk);
			busReq.rdStrobe <= 1'b0;
			#1;
			`CHK("cfgB readback", w & 16'h30f0, regRdData)
			`CHK("analog hot", 2'(i), cfgOut.analog_reg_hot_warn_sel)
			`CHK("io hot", 2'(3 - i), cfgOut.io_reg_hot_warn_sel)
			`CHK("high th", 1'(i & 1), cfgOut.io_supply_high_threshold_sel)
			`CHK("low th", 1'(i >> 1), cfgOut.io_supply_low_threshold_sel)
		end
		$display("test config b finished");
	endtask

	// Clock enables one at a time; reserved bits 9:3 written as ones, bits 15:10 kept at zero by software.
	task automatic testClock();
		for (int i = 0; i < 3; i++) begin
			busWrite(CLK_OFFSET, 16'h03f8 | (16'h0001 << i));
			checkRead("clk readback", CLK_OFFSET, 16'h0001 << i);
			`CHK("mclk wd", 1'(i == 0), cfgOut.main_clock_watchdog_on)
			`CHK("osc wd", 1'(i == 1), cfgOut.diag_osc_watchdog_on)
			`CHK("freq mon", 1'(i == 2), cfgOut.main_clock_freq_monitor_on)
		end
		$display("test clock finished");
	endtask

	// Self-test register layout, ground-open enable, and an unmapped read.
	task automatic testSelftestReg();
		busWrite(SELFTEST_OFFSET, 16'hffff);
		checkRead("selftest readback", SELFTEST_OFFSET, 16'hff87);
		busWrite(CFG_A_OFFSET, 16'h0001);
		`CHK("gnd open on", 1'b1, cfgOut.dig_ground_open_monitor_on)
		`CHK("gnd selftest", 16'h0001, cfgOut.selftestActive)
		// Back-to-back writes: every self-test bit, then every monitor enable.
		@(posedge ref_clk);
		busReq <= '{addr: SELFTEST_OFFSET, wrData: 16'hffff, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge ref_clk);
		busReq <= '{addr: CFG_A_OFFSET, wrData: 16'hffff, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge ref_clk);
		busReq.wrStrobe <= 1'b0;
		#1;
		`CHK("all selftest", 16'hff87, cfgOut.selftestActive)
		checkRead("unmapped", 8'h60, 16'h0000);
		$display("test self-test register finished");
	endtask

	// Self-test pass is gated by the monitor enable, then raises flag, status and irq.
	task automatic testSelftestFlag();
		int n;
		busWrite(CFG_A_OFFSET, 16'h0000);
		busWrite(SELFTEST_OFFSET, 16'h8000);
		busWrite(MASK_OFFSET, 16'h8000);
		@(posedge ref_clk);
		selftestDoneIn <= 16'h8000;
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("gated flag", 16'hffff, faultFlagN)
		`CHK("gated active", 16'h0000, cfgOut.selftestActive)
		`CHK("gated irq", 1'b0, irq)
		busWrite(CFG_A_OFFSET, 16'h8000);
		n = 0;
		while (faultFlagN[15] !== 1'b0 && n < 10) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		`CHK("flag low", 16'h7fff, faultFlagN)
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("irq set", 1'b1, irq)
		checkRead("status", STATUS_OFFSET, 16'h8000);
		@(posedge ref_clk);
		#1;
		`CHK("irq cleared", 1'b0, irq)
		checkRead("status clear", STATUS_OFFSET, 16'h0000);
		@(posedge ref_clk);
		selftestDoneIn <= 16'h0000;
		busWrite(CFG_A_OFFSET, 16'h0000);
		$display("test self-test flag finished");
	endtask

	task automatic completeRun();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence: reset for 12 cycles, then each test in turn.
	initial begin
		errTotal = 0;
		numChecks = 0;
		rst = 1'b1;
		busReq = '0;
		monitorTripIn = 16'h0000;
		selftestDoneIn = 16'h0000;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		testReset();
		testCfgB();
		testClock();
		testSelftestReg();
		testSelftestFlag();
		completeRun();
	end

	// Watchdog well beyond the fewer than a hundred cycles the tests need.
	initial begin
		#100000;
		errTotal++;
		completeRun();
	end
endmodule

`default_nettype wire
